// *** core/adc_host_pkg.sv ***
package adc_host_pkg;

    localparam int CLK_NS          = 100;

    // pin timing, in ns as specified
    localparam int T_START_LOW_NS  = 40;
    localparam int T_START_HIGH_NS = 20;
    localparam int T_CONV_MAX_NS   = 650;
    localparam int T_ACQ_MIN_NS    = 310;
    localparam int T_BUS_HOLD_NS   = 40;
    localparam int T_ABORT_MIN_NS  = 70;
    localparam int T_ABORT_MAX_NS  = 550;
    localparam int T_EN_NS         = 30;
    localparam int T_RD_LOW_NS     = 50;
    localparam int T_BYTE_GAP_NS   = 50;
    localparam int T_SETTLE_NS     = 600;

    function automatic int cyc_ceil(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_floor(input int ns);
        int c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int START_LOW_CYC   = cyc_ceil(T_START_LOW_NS);
    localparam int START_HIGH_CYC  = cyc_ceil(T_START_HIGH_NS);
    localparam int CONV_MAX_CYC    = cyc_floor(T_CONV_MAX_NS);
    localparam int ACQ_MIN_CYC     = cyc_ceil(T_ACQ_MIN_NS);
    localparam int BUS_HOLD_CYC    = cyc_ceil(T_BUS_HOLD_NS);
    localparam int ABORT_MIN_CYC   = cyc_ceil(T_ABORT_MIN_NS);
    localparam int ABORT_MAX_CYC   = cyc_floor(T_ABORT_MAX_NS);
    localparam int EN_CYC          = cyc_ceil(T_EN_NS);
    localparam int RD_LOW_CYC      = cyc_ceil(T_RD_LOW_NS);
    localparam int BYTE_GAP_CYC    = cyc_ceil(T_BYTE_GAP_NS);
    localparam int SETTLE_CYC      = cyc_ceil(T_SETTLE_NS);

    localparam int CNT_W           = 4;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CHSEL  = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0C;
    localparam logic [7:0] OFS_STEP   = 8'h10;

    // control bits
    localparam int CTRL_START      = 0;
    localparam int CTRL_ABORT      = 1;
    localparam int CTRL_BYTE_MODE  = 2;
    localparam int CTRL_AUTO       = 3;
    localparam int CTRL_REF_OFF    = 4;
    localparam int CTRL_FOLLOW     = 5;
    localparam int CTRL_RESTART    = 6;
    localparam int CTRL_W          = 7;

    // status bits
    localparam int ST_ACTIVE       = 0;
    localparam int ST_VALID        = 1;
    localparam int ST_TIMEOUT      = 2;
    localparam int ST_ABORTED      = 3;
    localparam int ST_CHAN_LO      = 4;
    localparam int ST_CHAN_HI      = 5;

    localparam logic [6:0]  CTRL_RESET = 7'h20;
    localparam logic [1:0]  CHAN_ZERO  = 2'h0;
    localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

    typedef enum logic [3:0] {
        S_IDLE, S_START, S_CONV, S_ABORT, S_READ_A, S_CAP_A, S_GAP, S_READ_B, S_CAP_B
    } seq_state_e;

endpackage

// *** core/sat_counter.sv ***
`timescale 1ns/1ns
module sat_counter #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // control
    input  wire logic         clear,
    output logic [W-1:0]      count
);
    // saturates so long idle gaps never wrap into a false short gap
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (count != {W{1'b1}}) begin
            count <= count + 1'b1;
        end
    end
endmodule

// *** core/adc_host.sv ***
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ns
module adc_host (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // converter control
    output logic             conversion_start_n,
    output logic             cs_n,
    output logic             rd_n,
    output logic             byte_select,
    output logic             bus_width_select,
    input  wire logic        busy,
    input  wire logic [15:0] result_bus,
    // selector and power
    output logic             sequence_auto,
    output logic             channel_select_low,
    output logic             channel_select_high,
    output logic             scan_restart,
    output logic             channel_step,
    output logic             reference_buffer_off
);
    localparam int W = adc_host_pkg::CNT_W;
    // conv_cnt is cleared one edge after start_n falls and first read one edge later
    localparam int START_LAG = 2;

    adc_host_pkg::seq_state_e state;
    adc_host_pkg::seq_state_e next_state;

    logic [adc_host_pkg::CTRL_W-1:0] ctrl;
    logic [1:0]  chsel;
    logic [15:0] result;
    logic        start_pend;
    logic        abort_pend;
    logic        valid;
    logic        timeout;
    logic        aborted;
    logic        step_pulse;
    logic [1:0]  chan;
    logic [W-1:0] conv_cnt;
    logic [W-1:0] acq_cnt;
    logic [W-1:0] settle_cnt;

    // apb decode
    wire access    = psel && penable && pready;
    wire wr        = access && pwrite;
    wire rd        = access && !pwrite;
    wire hit_ctrl  = paddr == adc_host_pkg::OFS_CTRL;
    wire hit_chsel = paddr == adc_host_pkg::OFS_CHSEL;
    wire hit_stat  = paddr == adc_host_pkg::OFS_STATUS;
    wire hit_res   = paddr == adc_host_pkg::OFS_RESULT;
    wire hit_step  = paddr == adc_host_pkg::OFS_STEP;
    wire mapped    = hit_ctrl || hit_chsel || hit_stat || hit_res || hit_step;
    wire next_pready = psel && penable && !pready;

    wire [31:0] status_word = {26'h0, chan, aborted, timeout, valid,
                               state != adc_host_pkg::S_IDLE};
    wire [31:0] read_word =
        hit_ctrl  ? {25'h0, ctrl} :
        hit_chsel ? {30'h0, chsel} :
        hit_stat  ? status_word :
        hit_res   ? {16'h0, result} : adc_host_pkg::RD_ZERO;

    wire start_req = wr && hit_ctrl && pwdata[adc_host_pkg::CTRL_START];
    wire abort_req = wr && hit_ctrl && pwdata[adc_host_pkg::CTRL_ABORT];
    wire step_req  = wr && hit_step && pwdata[0];
    wire clr_valid = rd && hit_res;

    // timing gates
    wire acq_ok     = acq_cnt >= W'(adc_host_pkg::ACQ_MIN_CYC);
    wire settle_ok  = settle_cnt >= W'(adc_host_pkg::SETTLE_CYC);
    wire can_start  = start_pend && acq_ok && settle_ok && !busy;
    wire hold_ok    = conv_cnt >= W'(adc_host_pkg::BUS_HOLD_CYC);
    // edges since start_n fell, so the abort window is measured from the start edge
    wire [W:0] conv_age = {1'b0, conv_cnt} + (W+1)'(START_LAG);
    wire abort_win  = conv_age >= (W+1)'(adc_host_pkg::ABORT_MIN_CYC) &&
                      conv_age <= (W+1)'(adc_host_pkg::ABORT_MAX_CYC);
    wire conv_late  = conv_cnt > W'(adc_host_pkg::CONV_MAX_CYC);
    wire byte_mode  = bus_width_select;

    // channel-step source and selector model
    wire next_step  = ctrl[adc_host_pkg::CTRL_FOLLOW] ? busy : step_pulse;
    wire step_rise  = next_step && !channel_step;
    wire [1:0] sel_pins = {channel_select_high, channel_select_low};
    wire [1:0] next_chan =
        !sequence_auto ? sel_pins :
        scan_restart   ? adc_host_pkg::CHAN_ZERO :
        (chan == sel_pins) ? adc_host_pkg::CHAN_ZERO :
        chan + 2'h1;

    always_comb begin
        next_state = state;
        unique case (state)
            adc_host_pkg::S_IDLE:   if (can_start) next_state = adc_host_pkg::S_START;
            adc_host_pkg::S_START:  next_state = adc_host_pkg::S_CONV;
            adc_host_pkg::S_CONV: begin
                if (abort_pend && abort_win && busy) next_state = adc_host_pkg::S_ABORT;
                else if (!busy && hold_ok) next_state = adc_host_pkg::S_READ_A;
                else if (conv_late) next_state = adc_host_pkg::S_IDLE;
            end
            adc_host_pkg::S_ABORT:  next_state = adc_host_pkg::S_IDLE;
            adc_host_pkg::S_READ_A: next_state = adc_host_pkg::S_CAP_A;
            adc_host_pkg::S_CAP_A:  next_state = byte_mode ? adc_host_pkg::S_GAP :
                                                             adc_host_pkg::S_IDLE;
            adc_host_pkg::S_GAP:    next_state = adc_host_pkg::S_READ_B;
            adc_host_pkg::S_READ_B: next_state = adc_host_pkg::S_CAP_B;
            adc_host_pkg::S_CAP_B:  next_state = adc_host_pkg::S_IDLE;
        endcase
    end

    sat_counter #(.W(W)) u_conv (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clear   (state == adc_host_pkg::S_START),
        .count   (conv_cnt)
    );

    sat_counter #(.W(W)) u_acq (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clear   (busy || state == adc_host_pkg::S_START),
        .count   (acq_cnt)
    );

    sat_counter #(.W(W)) u_settle (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clear   (step_rise),
        .count   (settle_cnt)
    );

    // apb registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= adc_host_pkg::RD_ZERO;
            ctrl    <= adc_host_pkg::CTRL_RESET;
            chsel   <= adc_host_pkg::CHAN_ZERO;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pready && !mapped;
            prdata  <= next_pready && !pwrite ? read_word : adc_host_pkg::RD_ZERO;
            if (wr && hit_ctrl) begin
                ctrl <= pwdata[adc_host_pkg::CTRL_W-1:0] &
                        ~adc_host_pkg::CTRL_W'(3);
            end
            if (wr && hit_chsel) begin
                chsel <= pwdata[1:0];
            end
        end
    end

    // requests and sticky status; a set in the clearing cycle wins
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            start_pend <= 1'b0;
            abort_pend <= 1'b0;
            valid      <= 1'b0;
            timeout    <= 1'b0;
            aborted    <= 1'b0;
            step_pulse <= 1'b0;
        end else begin
            start_pend <= start_req || (start_pend && state != adc_host_pkg::S_START);
            abort_pend <= abort_req || (abort_pend && state == adc_host_pkg::S_CONV);
            valid      <= (next_state == adc_host_pkg::S_IDLE &&
                           (state == adc_host_pkg::S_CAP_B ||
                           (state == adc_host_pkg::S_CAP_A && !byte_mode))) ||
                          (valid && !clr_valid);
            timeout    <= (state == adc_host_pkg::S_CONV &&
                           next_state == adc_host_pkg::S_IDLE) ||
                          (timeout && !start_req);
            aborted    <= (state == adc_host_pkg::S_ABORT) || (aborted && !start_req);
            step_pulse <= step_req && !step_pulse;
        end
    end

    // pin drive; width, mode and selects only change while idle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state                <= adc_host_pkg::S_IDLE;
            conversion_start_n   <= 1'b1;
            cs_n                 <= 1'b1;
            rd_n                 <= 1'b1;
            byte_select          <= 1'b0;
            bus_width_select     <= 1'b0;
            sequence_auto        <= 1'b0;
            channel_select_low   <= 1'b0;
            channel_select_high  <= 1'b0;
            scan_restart         <= 1'b0;
            channel_step         <= 1'b0;
            reference_buffer_off <= 1'b0;
            chan                 <= adc_host_pkg::CHAN_ZERO;
            result               <= 16'h0000;
        end else begin
            state                <= next_state;
            conversion_start_n   <= !(next_state == adc_host_pkg::S_START);
            cs_n                 <= !(next_state inside {adc_host_pkg::S_ABORT,
                                      adc_host_pkg::S_READ_A, adc_host_pkg::S_CAP_A,
                                      adc_host_pkg::S_GAP, adc_host_pkg::S_READ_B,
                                      adc_host_pkg::S_CAP_B});
            rd_n                 <= !(next_state inside {adc_host_pkg::S_READ_A,
                                      adc_host_pkg::S_CAP_A, adc_host_pkg::S_READ_B,
                                      adc_host_pkg::S_CAP_B});
            byte_select          <= next_state inside {adc_host_pkg::S_GAP,
                                      adc_host_pkg::S_READ_B, adc_host_pkg::S_CAP_B};
            reference_buffer_off <= ctrl[adc_host_pkg::CTRL_REF_OFF];
            channel_step         <= next_step;
            if (state == adc_host_pkg::S_IDLE && next_state == adc_host_pkg::S_IDLE) begin
                bus_width_select    <= ctrl[adc_host_pkg::CTRL_BYTE_MODE];
                sequence_auto       <= ctrl[adc_host_pkg::CTRL_AUTO];
                scan_restart        <= ctrl[adc_host_pkg::CTRL_RESTART];
                channel_select_low  <= chsel[0];
                channel_select_high <= chsel[1];
            end
            if (step_rise) begin
                chan <= next_chan;
            end
            // data is sampled two full cycles after the strobe fell
            if (state == adc_host_pkg::S_CAP_A) begin
                if (byte_mode) begin
                    result[15:8] <= result_bus[15:8];
                end else begin
                    result <= result_bus;
                end
            end
            if (state == adc_host_pkg::S_CAP_B) begin
                result[7:0] <= result_bus[15:8];
            end
        end
    end
endmodule

// *** verif/adc_host_properties.sv ***
`timescale 1ns/1ns
module adc_host_properties (
    // clock, reset and apb handshake
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic psel,
    input  wire logic penable,
    input  wire logic pready,
    // converter and selector pins
    input  wire logic conversion_start_n,
    input  wire logic cs_n,
    input  wire logic rd_n,
    input  wire logic byte_select,
    input  wire logic bus_width_select,
    input  wire logic busy,
    input  wire logic channel_select_low,
    input  wire logic channel_select_high,
    input  wire logic channel_step
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // cycles since the start strobe, parked at 15 so it never wraps into a false window
    logic [3:0] since_start;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) since_start <= 4'hF;
        else if (!conversion_start_n) since_start <= 4'h0;
        else if (since_start != 4'hF) since_start <= since_start + 4'h1;
    end
    sequence s_start; $fell(conversion_start_n); endsequence
    sequence s_wait; psel && penable && !pready; endsequence
    property p_start_pulse; s_start |=> conversion_start_n; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start strobe too long");
    property p_quiet; s_start |-> cs_n && rd_n && $stable(byte_select)
        && $stable(bus_width_select) ##1 rd_n; endproperty
    a_quiet: assert property (p_quiet) else $error("bus moved right after start");
    // busy rises right after the start fall, so the gap is the four samples before it
    property p_acq; s_start |-> !$past(busy) && !$past(busy, 2) && !$past(busy, 3)
        && !$past(busy, 4); endproperty
    a_acq: assert property (p_acq) else $error("start without acquisition gap");
    property p_settle; $rose(channel_step) |-> conversion_start_n [*6]; endproperty
    a_settle: assert property (p_settle) else $error("start too soon after step");
    property p_read; $fell(rd_n) |-> !busy && !cs_n ##1 !rd_n && !cs_n; endproperty
    a_read: assert property (p_read) else $error("read strobe misplaced");
    property p_width; $changed(byte_select) || $changed(bus_width_select) |-> rd_n; endproperty
    a_width: assert property (p_width) else $error("width select moved under strobe");
    // the converter drops busy at the select fall itself, so look one sample back
    property p_abort; $fell(cs_n) && $past(busy) |-> since_start <= 4'h4; endproperty
    a_abort: assert property (p_abort) else $error("abort outside window");
    property p_step; $rose(channel_step) |-> $stable(channel_select_low)
        && $stable(channel_select_high); endproperty
    a_step: assert property (p_step) else $error("address moved at step");
    property p_apb; s_wait |=> pready ##1 !pready; endproperty
    a_apb: assert property (p_apb) else $error("apb answer late or long");
endmodule
bind adc_host adc_host_properties chk_u (.clk_sys, .rstn, .psel, .penable, .pready,
    .conversion_start_n, .cs_n, .rd_n, .byte_select, .bus_width_select, .busy,
    .channel_select_low, .channel_select_high, .channel_step);

// *** verif/adc_dev_model.sv ***
`timescale 1ns/1ns
module adc_dev_model (
    // conversion and read pins
    input  wire logic        conversion_start_n,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        byte_select,
    input  wire logic        bus_width_select,
    output logic             busy,
    output logic [15:0]      result_bus,
    // selector, power and test knobs
    input  wire logic        sequence_auto,
    input  wire logic        channel_select_low,
    input  wire logic        channel_select_high,
    input  wire logic        scan_restart,
    input  wire logic        channel_step,
    input  wire logic        reference_buffer_off,
    input  wire logic [15:0] sample,
    input  wire logic [15:0] conv_ns,
    output logic [1:0]       chan,
    output logic             ref_on
);
    logic [15:0] word;
    logic [15:0] bus_val;
    logic [1:0]  addr;
    assign addr = {channel_select_high, channel_select_low};
    assign ref_on = !reference_buffer_off;
    assign bus_val = (bus_width_select && byte_select) ? {word[7:0], 8'hFF} : word;
    // released bus shows the inverse, so a late capture cannot pass by luck
    assign #20 result_bus = (!rd_n || !cs_n) ? bus_val : ~bus_val;
    initial begin
        busy = 1'b0;
        chan = 2'h0;
        word = 16'h0000;
    end
    always @(negedge conversion_start_n) begin
        if (busy && !cs_n) busy <= 1'b0;
        else if (!busy) begin
            busy <= #20 1'b1;
            busy <= #(conv_ns) 1'b0;
        end
    end
    always @(negedge cs_n) if (busy) busy <= 1'b0;
    always @(negedge busy) word = sample;
    always @(posedge channel_step) begin
        if (!sequence_auto) chan <= addr;
        else if (scan_restart || chan == addr) chan <= 2'h0;
        else chan <= chan + 2'h1;
    end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, busy, ref_on, perr;
    logic        conversion_start_n, cs_n, rd_n, byte_select, bus_width_select;
    logic        sequence_auto, channel_select_low, channel_select_high, scan_restart;
    logic        channel_step, reference_buffer_off;
    logic [1:0]  chan;
    logic [7:0]  paddr;
    logic [15:0] result_bus, sample, conv_ns;
    logic [31:0] pwdata, prdata, rd;
    int          errors, samples_checked;

    adc_host dut_u (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .conversion_start_n, .cs_n, .rd_n, .byte_select, .bus_width_select,
        .busy, .result_bus, .sequence_auto, .channel_select_low, .channel_select_high,
        .scan_restart, .channel_step, .reference_buffer_off);
    adc_dev_model dev_u (.conversion_start_n, .cs_n, .rd_n, .byte_select, .bus_width_select,
        .busy, .result_bus, .sequence_auto, .channel_select_low, .channel_select_high,
        .scan_restart, .channel_step, .reference_buffer_off, .sample, .conv_ns, .chan, .ref_on);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up;
        if (errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one transfer then an idle cycle; the bound only guards against a dead slave
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rd = prdata;
        perr = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge clk_sys);
    endtask

    task automatic conv(input logic [31:0] ctl, input logic [15:0] s, input logic [15:0] t);
        {sample, conv_ns} <= {s, t};
        apb(1'b1, adc_host_pkg::OFS_CTRL, ctl);
    endtask

    // poll until valid, timeout or aborted shows up
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            apb(1'b0, adc_host_pkg::OFS_STATUS, 32'h0);
            n++;
        end while (rd[3:1] == 3'h0 && n < 40);
        if (rd[3:1] == 3'h0) errors++;
    endtask

    task automatic step_chk(input logic [1:0] exp);
        apb(1'b1, adc_host_pkg::OFS_STEP, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk("model channel", {30'h0, exp}, {30'h0, chan});
        apb(1'b0, adc_host_pkg::OFS_STATUS, 32'h0);
        chk("status channel", {30'h0, exp}, {30'h0, rd[5:4]});
    endtask

    initial begin
        #3000000;
        errors++;
        wrap_up();
    end

    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = 43'h0;
        {sample, conv_ns} = 32'h0;
        {errors, samples_checked} = 64'h0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, adc_host_pkg::OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0000_0020, rd);
        apb(1'b0, adc_host_pkg::OFS_STATUS, 32'h0);
        chk("status reset", 32'h0, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, perr});
        conv(32'h0000_0021, 16'hA5C3, 16'h01C2);
        wait_done;
        chk("status word", 32'h2, rd & 32'hE);
        apb(1'b0, adc_host_pkg::OFS_RESULT, 32'h0);
        chk("word result", 32'h0000_A5C3, rd);
        // width pins only move while idle, so set byte mode before the start
        apb(1'b1, adc_host_pkg::OFS_CTRL, 32'h0000_0024);
        conv(32'h0000_0025, 16'h3C96, 16'h0258);
        wait_done;
        apb(1'b0, adc_host_pkg::OFS_RESULT, 32'h0);
        chk("byte result", 32'h0000_3C96, rd);
        conv(32'h0000_0021, 16'h1234, 16'h03E8);
        wait_done;
        chk("timeout flag", 32'h4, rd & 32'hE);
        repeat (20) @(posedge clk_sys);
        conv(32'h0000_0021, 16'h5A5A, 16'h0226);
        apb(1'b1, adc_host_pkg::OFS_CTRL, 32'h0000_0022);
        wait_done;
        chk("aborted flag", 32'h8, rd & 32'hE);
        // abort request landing 600 ns after the start must be refused
        repeat (8) @(posedge clk_sys);
        conv(32'h0000_0021, 16'h6B2D, 16'h0280);
        repeat (2) @(posedge clk_sys);
        apb(1'b1, adc_host_pkg::OFS_CTRL, 32'h0000_0022);
        wait_done;
        chk("late abort refused", 32'h2, rd & 32'hE);
        // manual mode with restart high, which must be ignored
        apb(1'b1, adc_host_pkg::OFS_CTRL, 32'h0000_0050);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, adc_host_pkg::OFS_CHSEL, 32'(c));
            step_chk(2'(c));
        end
        chk("buffer off", 32'h0, {31'h0, ref_on});
        apb(1'b1, adc_host_pkg::OFS_CHSEL, 32'h1);
        repeat (4) @(posedge clk_sys);
        chk("channel held", 32'h3, {30'h0, chan});
        apb(1'b1, adc_host_pkg::OFS_CTRL, 32'h0000_0048);
        apb(1'b1, adc_host_pkg::OFS_CHSEL, 32'h2);
        step_chk(2'h0);
        apb(1'b1, adc_host_pkg::OFS_CTRL, 32'h0000_0008);
        for (int i = 1; i < 6; i++) step_chk(2'(i % 3));
        chk("buffer on", 32'h1, {31'h0, ref_on});
        wrap_up();
    end
endmodule
